// >>> rtl/page_pkg.sv
package page_pkg;
    localparam int PAGE_W = 6;
    localparam int ADDR_W = 16;
    localparam int STACK_W = 16;
    localparam logic [5:0] PAGE_RESET = 6'h00;
    localparam logic [15:0] WINDOW_BASE = 16'h8000;
    localparam logic [15:0] WINDOW_LAST = 16'hBFFF;
    // ------------------------------------------------------------
    // 16K blocks, by the top two address bits
    // ------------------------------------------------------------
    localparam logic [1:0] REGION_LOW = 2'h0;
    localparam logic [1:0] REGION_MID = 2'h1;
    localparam logic [1:0] REGION_WIN = 2'h2;
    localparam logic [1:0] REGION_TOP = 2'h3;
    // ------------------------------------------------------------
    // Partition straps and internal boundaries
    // ------------------------------------------------------------
    localparam logic [1:0] STRAP_128K = 2'h0;
    localparam logic [1:0] STRAP_256K = 2'h1;
    localparam logic [1:0] STRAP_512K = 2'h2;
    localparam logic [1:0] STRAP_1M = 2'h3;
    localparam logic [5:0] BOUND_128K = 6'h38;
    localparam logic [5:0] BOUND_256K = 6'h30;
    localparam logic [5:0] BOUND_512K = 6'h20;
    // ------------------------------------------------------------
    // Fixed extended address values outside the window
    // ------------------------------------------------------------
    localparam logic [5:0] XAB_LOW = 6'h3D;
    localparam logic [5:0] XAB_MID = 6'h3E;
    localparam logic [5:0] XAB_TOP = 6'h3F;
    localparam logic [5:0] DRIVE_ALL = 6'h3F;
    // ------------------------------------------------------------
    // Allocated physical program memory
    // ------------------------------------------------------------
    localparam logic [1:0] ALLOC_0K = 2'h0;
    localparam logic [1:0] ALLOC_16K = 2'h1;
    localparam logic [1:0] ALLOC_48K = 2'h2;
    localparam logic [1:0] ALLOC_64K = 2'h3;
    typedef enum logic [3:0] {
        SEQ_IDLE = 4'b0000,
        SEQ_FETCH = 4'b0001,
        SEQ_PUSH_RET = 4'b0010,
        SEQ_PUSH_PAGE = 4'b0011,
        SEQ_POP_PAGE = 4'b0100,
        SEQ_POP_RET = 4'b0101,
        SEQ_RTC_WRITE = 4'b0110,
        SEQ_FINISH = 4'b0111
    } seq_state_t;
endpackage

// >>> rtl/page_region_decode.sv
`timescale 1ns/10ps
module page_region_decode (
    input wire logic [1:0] addr_hi,
    input wire logic [5:0] page_index,
    input wire logic [1:0] straps,
    input wire logic [1:0] alloc,
    input wire logic high_map,
    output logic page_internal,
    output logic [5:0] xab_value,
    output logic sel_raw_n
);
    logic [5:0] boundary;
    logic alloc_big;
    logic sel_low;
    logic sel_mid;
    logic sel_win;
    logic sel_any;

    assign boundary = (straps == page_pkg::STRAP_128K) ? page_pkg::BOUND_128K :
                      (straps == page_pkg::STRAP_256K) ? page_pkg::BOUND_256K :
                      page_pkg::BOUND_512K;
    assign page_internal = (straps == page_pkg::STRAP_1M) || (page_index >= boundary);

    assign xab_value = (addr_hi == page_pkg::REGION_LOW) ? page_pkg::XAB_LOW :
                       (addr_hi == page_pkg::REGION_MID) ? page_pkg::XAB_MID :
                       (addr_hi == page_pkg::REGION_WIN) ? page_index :
                       page_pkg::XAB_TOP;

    assign alloc_big = (alloc == page_pkg::ALLOC_48K) || (alloc == page_pkg::ALLOC_64K);
    assign sel_low = (alloc == page_pkg::ALLOC_64K) && !high_map;
    assign sel_mid = alloc_big && !high_map;
    assign sel_win = (alloc == page_pkg::ALLOC_0K) || (alloc_big && page_internal);
    assign sel_any = (addr_hi == page_pkg::REGION_LOW) ? sel_low :
                     (addr_hi == page_pkg::REGION_MID) ? sel_mid :
                     (addr_hi == page_pkg::REGION_WIN) ? sel_win : 1'b1;
    assign sel_raw_n = !sel_any;
endmodule // page_region_decode

// >>> rtl/program_page_expansion_decode.sv
// Notes on behaviour
// - Six-bit page index selects which 16K page shows at 0x8000-0xBFFF.
// - Two-bit strap sets on-chip share: 128K, 256K, 512K or 1M.
// - Window access internal at or above strap boundary 0x38, 0x30, 0x20.
// - Page register read and written by stores, far call and far return.
// - Top block 0xC000-0xFFFF is never paged.
// - Far call saves page, loads new, pushes return then old page, jumps.
// - Far call sequence runs with interrupts held off.
// - Indexed-indirect far call fetches page and target from memory.
// - Far return pops page, pops return address, restores page, refills.
// - Far return runs uninterrupted and may start from any address.
// - Page bits drive extended address lines in window when emulating expanded.
// - Fixed extended codes 0x3D, 0x3E, 0x3F outside the window.
// - Zero allocation: select high for low half, low elsewhere.
// - 48K allocation: select low at top, internal window, middle if map clear.
// - 64K allocation: high map bit also governs the lowest block.
// - Extended address and select shown only when emulating and expanded.
// - With emulation enable, port K bit 7 is the select; else GPIO.
// - External select only when emulation select idle and external space hit.
// - Ordinary page store takes effect one cycle later.
`timescale 1ns/10ps
module program_page_expansion_decode #(
    parameter logic [5:0] RESET_PAGE = page_pkg::PAGE_RESET
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [1:0] partition_straps,
    input wire logic [1:0] alloc_code,
    input wire logic expanded_mode,
    input wire logic portk_emulation_enable,
    input wire logic rom_high_map_bit,
    input wire logic page_write_lock,
    input wire logic bus_valid,
    input wire logic [15:0] bus_addr,
    input wire logic bus_external,
    input wire logic bus_unmapped,
    input wire logic page_wr_en,
    input wire logic [5:0] page_wr_data,
    input wire logic call_req,
    input wire logic call_indirect,
    input wire logic [5:0] call_imm_page,
    input wire logic [15:0] call_target,
    input wire logic [15:0] call_ret_addr,
    input wire logic rtc_req,
    input wire logic fetch_ack,
    input wire logic [5:0] fetch_page,
    input wire logic [15:0] fetch_target,
    input wire logic stack_ack,
    input wire logic [15:0] stack_rdata,
    input wire logic [7:0] portk_gpio_out,
    input wire logic [7:0] portk_gpio_oe,
    output logic [5:0] page_index_bits,
    output logic window_internal,
    output logic fetch_req,
    output logic stack_req,
    output logic stack_write,
    output logic [15:0] stack_wdata,
    output logic pc_load,
    output logic [15:0] pc_value,
    output logic queue_refill,
    output logic irq_inhibit,
    output logic seq_done,
    output logic [7:0] portk_out,
    output logic [7:0] portk_oe
);
    // ------------------------------------------------------------
    // Page register and pending store
    // ------------------------------------------------------------
    page_pkg::seq_state_t state_r;
    page_pkg::seq_state_t state_nxt;
    logic [5:0] page_r;
    logic [5:0] page_nxt;
    logic [5:0] temp_r;
    logic [5:0] wr_data_r;
    logic wr_pend_r;
    logic [15:0] target_r;
    logic idle;
    logic wr_take;
    logic imm_load;
    logic fetch_load;
    logic rtc_load;
    logic [5:0] page_eff;

    assign idle = (state_r == page_pkg::SEQ_IDLE);
    // stores accepted unless locked or busy
    assign wr_take = page_wr_en && !page_write_lock && idle && !call_req && !rtc_req;
    assign imm_load = idle && call_req && !call_indirect;
    assign fetch_load = (state_r == page_pkg::SEQ_FETCH) && fetch_ack;
    assign rtc_load = (state_r == page_pkg::SEQ_RTC_WRITE);
    assign page_eff = wr_pend_r ? wr_data_r : page_r;
    // pending store lands one cycle on
    assign page_nxt = rtc_load ? temp_r :
                      fetch_load ? fetch_page :
                      imm_load ? call_imm_page :
                      page_eff;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_pend_r <= 1'b0;
            wr_data_r <= page_pkg::PAGE_RESET;
        end else if (clk_en) begin
            wr_pend_r <= wr_take;
            wr_data_r <= page_wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            page_r <= RESET_PAGE;
        end else if (clk_en) begin
            page_r <= page_nxt;
        end
    end

    // ------------------------------------------------------------
    // Far call and far return sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            page_pkg::SEQ_IDLE: begin
                if (call_req) begin
                    state_nxt = call_indirect ? page_pkg::SEQ_FETCH : page_pkg::SEQ_PUSH_RET;
                end else if (rtc_req) begin
                    state_nxt = page_pkg::SEQ_POP_PAGE;
                end
            end
            page_pkg::SEQ_FETCH: begin
                if (fetch_ack) state_nxt = page_pkg::SEQ_PUSH_RET;
            end
            page_pkg::SEQ_PUSH_RET: begin
                if (stack_ack) state_nxt = page_pkg::SEQ_PUSH_PAGE;
            end
            page_pkg::SEQ_PUSH_PAGE: begin
                if (stack_ack) state_nxt = page_pkg::SEQ_FINISH;
            end
            page_pkg::SEQ_POP_PAGE: begin
                if (stack_ack) state_nxt = page_pkg::SEQ_POP_RET;
            end
            page_pkg::SEQ_POP_RET: begin
                if (stack_ack) state_nxt = page_pkg::SEQ_RTC_WRITE;
            end
            page_pkg::SEQ_RTC_WRITE: state_nxt = page_pkg::SEQ_FINISH;
            default: state_nxt = page_pkg::SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= page_pkg::SEQ_IDLE;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            temp_r <= page_pkg::PAGE_RESET;
            target_r <= 16'h0000;
            fetch_req <= 1'b0;
            stack_req <= 1'b0;
            stack_write <= 1'b0;
            stack_wdata <= 16'h0000;
            pc_load <= 1'b0;
            pc_value <= 16'h0000;
            queue_refill <= 1'b0;
            irq_inhibit <= 1'b0;
            seq_done <= 1'b0;
        end else if (clk_en) begin
            pc_load <= 1'b0;
            queue_refill <= 1'b0;
            seq_done <= 1'b0;
            case (state_r)
                page_pkg::SEQ_IDLE: begin
                    if (call_req) begin
                        temp_r <= page_eff;
                        target_r <= call_target;
                        stack_wdata <= call_ret_addr;
                        irq_inhibit <= 1'b1;
                        fetch_req <= call_indirect;
                        stack_req <= !call_indirect;
                        stack_write <= 1'b1;
                    end else if (rtc_req) begin
                        // return from any address, held off
                        irq_inhibit <= 1'b1;
                        stack_req <= 1'b1;
                        stack_write <= 1'b0;
                    end
                end
                page_pkg::SEQ_FETCH: begin
                    if (fetch_ack) begin
                        fetch_req <= 1'b0;
                        target_r <= fetch_target;
                        stack_req <= 1'b1;
                    end
                end
                page_pkg::SEQ_PUSH_RET: begin
                    // old page pushed after return address
                    if (stack_ack) stack_wdata <= {10'h000, temp_r};
                end
                page_pkg::SEQ_PUSH_PAGE: begin
                    if (stack_ack) begin
                        stack_req <= 1'b0;
                        stack_write <= 1'b0;
                        pc_load <= 1'b1;
                        pc_value <= target_r;
                    end
                end
                page_pkg::SEQ_POP_PAGE: begin
                    if (stack_ack) temp_r <= stack_rdata[5:0];
                end
                page_pkg::SEQ_POP_RET: begin
                    if (stack_ack) begin
                        stack_req <= 1'b0;
                        pc_load <= 1'b1;
                        pc_value <= stack_rdata;
                    end
                end
                page_pkg::SEQ_FINISH: begin
                    queue_refill <= 1'b1;
                    seq_done <= 1'b1;
                    irq_inhibit <= 1'b0;
                end
                default: begin
                    stack_req <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Window decode and port K drive
    // ------------------------------------------------------------
    logic page_internal;
    logic [5:0] xab_value;
    logic sel_raw_n;
    logic emu_on;
    logic emu_sel_n_nxt;
    logic ext_sel_n_nxt;
    logic [7:0] portk_out_nxt;
    logic [7:0] portk_oe_nxt;

    page_region_decode page_region_decode_inst (
        .addr_hi(bus_addr[15:14]),
        .page_index(page_r),
        .straps(partition_straps),
        .alloc(alloc_code),
        .high_map(rom_high_map_bit),
        .page_internal(page_internal),
        .xab_value(xab_value),
        .sel_raw_n(sel_raw_n)
    );

    // shown only when emulating and expanded
    assign emu_on = portk_emulation_enable && expanded_mode;
    // top block decodes as fixed, never paged
    assign emu_sel_n_nxt = !(emu_on && bus_valid && !sel_raw_n);
    // external select needs idle emulation select
    assign ext_sel_n_nxt = !(emu_on && bus_valid && sel_raw_n && bus_external && !bus_unmapped);
    assign portk_out_nxt[5:0] = emu_on ? xab_value : portk_gpio_out[5:0];
    assign portk_oe_nxt[5:0] = emu_on ? page_pkg::DRIVE_ALL : portk_gpio_oe[5:0];
    // bit 7 select or general purpose
    assign portk_out_nxt[7] = portk_emulation_enable ? emu_sel_n_nxt : portk_gpio_out[7];
    assign portk_oe_nxt[7] = portk_emulation_enable || portk_gpio_oe[7];
    assign portk_out_nxt[6] = portk_emulation_enable ? ext_sel_n_nxt : portk_gpio_out[6];
    assign portk_oe_nxt[6] = portk_emulation_enable || portk_gpio_oe[6];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            portk_out <= 8'h00;
            portk_oe <= 8'h00;
            window_internal <= 1'b0;
            page_index_bits <= page_pkg::PAGE_RESET;
        end else if (clk_en) begin
            portk_out <= portk_out_nxt;
            portk_oe <= portk_oe_nxt;
            window_internal <= page_internal;
            page_index_bits <= page_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    logic [5:0] bound_chk;
    assign bound_chk = (partition_straps == page_pkg::STRAP_128K) ? page_pkg::BOUND_128K :
                       (partition_straps == page_pkg::STRAP_256K) ? page_pkg::BOUND_256K :
                       page_pkg::BOUND_512K;

    store_delay_a: assert property (
        wr_take && clk_en ##1 clk_en && !call_req |=> page_r == $past(page_wr_data, 2))
        else $error("page store not applied one cycle later");
    window_pix_a: assert property (
        clk_en && emu_on && bus_addr >= page_pkg::WINDOW_BASE
        && bus_addr <= page_pkg::WINDOW_LAST
        |=> portk_out[5:0] == $past(page_r) && portk_oe[5:0] == page_pkg::DRIVE_ALL)
        else $error("window address lines do not carry page index");
    fixed_code_a: assert property (
        clk_en && emu_on && bus_addr[15:14] == page_pkg::REGION_MID
        |=> portk_out[5:0] == page_pkg::XAB_MID)
        else $error("wrong fixed extended code in middle block");
    internal_bound_a: assert property (
        clk_en |=> window_internal == ($past(partition_straps) == page_pkg::STRAP_1M
        || $past(page_r) >= $past(bound_chk)))
        else $error("window classification wrong");
    call_held_a: assert property (
        !idle && state_r != page_pkg::SEQ_FINISH |-> irq_inhibit)
        else $error("interrupts open during far sequence");
    push_order_a: assert property (
        clk_en && state_r == page_pkg::SEQ_PUSH_RET && stack_ack
        |=> stack_req && stack_write && stack_wdata == {10'h000, $past(temp_r)})
        else $error("old page not pushed after return address");
    rtc_restore_a: assert property (
        clk_en && rtc_load |=> page_r == $past(temp_r) ##0 state_r == page_pkg::SEQ_FINISH)
        else $error("far return did not restore page");
    top_select_a: assert property (
        clk_en && emu_on && bus_valid && bus_addr[15:14] == page_pkg::REGION_TOP
        |=> !portk_out[7] && portk_out[5:0] == page_pkg::XAB_TOP)
        else $error("top block not selected as unpaged");
    zero_alloc_a: assert property (
        clk_en && emu_on && bus_valid && alloc_code == page_pkg::ALLOC_0K
        |=> portk_out[7] == !$past(bus_addr[15]))
        else $error("zero allocation select wrong");
    high_map_a: assert property (
        clk_en && emu_on && bus_valid && alloc_code == page_pkg::ALLOC_64K
        && bus_addr[15:14] == page_pkg::REGION_LOW
        |=> portk_out[7] == $past(rom_high_map_bit))
        else $error("high map bit ignored in low block");
    select_excl_a: assert property (
        clk_en && portk_emulation_enable |=> portk_out[7] || portk_out[6])
        else $error("both chip selects active");
    gpio_pass_a: assert property (
        clk_en && !portk_emulation_enable |=> portk_out[7] == $past(portk_gpio_out[7]))
        else $error("bit 7 not general purpose");

    call_indirect_c: cover property (
        idle && call_req && call_indirect && clk_en ##[1:20] seq_done);
    rtc_done_c: cover property (idle && rtc_req && clk_en ##[1:20] seq_done);
    store_c: cover property (wr_take && clk_en ##2 page_r == page_wr_data);
    window_sel_c: cover property (emu_on && bus_valid && page_internal && clk_en);
endmodule // program_page_expansion_decode

// >>> test/page_stack_model.sv
`timescale 1ns/10ps
module page_stack_model #(
    parameter logic [5:0] IND_PAGE = 6'h2A,
    parameter logic [15:0] IND_TARGET = 16'hA55A
) (
    input wire logic clk_sys,
    input wire logic slow,
    input wire logic fetch_req,
    input wire logic stack_req,
    input wire logic stack_write,
    input wire logic [15:0] stack_wdata,
    output logic fetch_ack,
    output logic [5:0] fetch_page,
    output logic [15:0] fetch_target,
    output logic stack_ack,
    output logic [15:0] stack_rdata
);
    logic [15:0] mem [0:15];
    logic [3:0] sp;
    logic [1:0] cnt;
    logic go;
    // Slow mode answers one cycle in four
    assign go = !slow || cnt == 2'h3;
    // Released lines show the inverse
    assign fetch_page = fetch_ack ? IND_PAGE : ~IND_PAGE;
    assign fetch_target = fetch_ack ? IND_TARGET : ~IND_TARGET;
    assign stack_rdata = stack_ack ? mem[sp - 4'h1] : ~mem[sp - 4'h1];
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'h0;
        end
        sp = 4'h0;
        cnt = 2'h0;
        fetch_ack = 1'b0;
        stack_ack = 1'b0;
    end
    always @(posedge clk_sys) begin
        cnt <= cnt + 2'h1;
        fetch_ack <= fetch_req && !fetch_ack && go;
        stack_ack <= stack_req && !stack_ack && go;
        if (stack_req && stack_ack) begin
            if (stack_write) begin
                mem[sp] <= stack_wdata;
                sp <= sp + 4'h1;
            end else begin
                sp <= sp - 4'h1;
            end
        end
    end
endmodule // page_stack_model

// >>> test/tb_program_page_expansion_decode.sv
`timescale 1ns/10ps
module tb_program_page_expansion_decode;
    logic clk_sys, reset, clk_en, expanded_mode, portk_emulation_enable, rom_high_map_bit;
    logic page_write_lock, bus_valid, bus_external, bus_unmapped, page_wr_en, call_req;
    logic call_indirect, rtc_req, fetch_ack, stack_ack, slow, window_internal, fetch_req;
    logic stack_req, stack_write, pc_load, queue_refill, irq_inhibit, seq_done;
    logic [1:0] partition_straps, alloc_code;
    logic [5:0] page_wr_data, call_imm_page, fetch_page, page_index_bits;
    logic [15:0] bus_addr, call_target, call_ret_addr, fetch_target, stack_rdata;
    logic [15:0] stack_wdata, pc_value;
    logic [7:0] portk_out, portk_oe;
    int fails, num_checks;

    program_page_expansion_decode program_page_expansion_decode_inst (
        .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
        .partition_straps(partition_straps), .alloc_code(alloc_code),
        .expanded_mode(expanded_mode), .portk_emulation_enable(portk_emulation_enable),
        .rom_high_map_bit(rom_high_map_bit), .page_write_lock(page_write_lock),
        .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_external(bus_external),
        .bus_unmapped(bus_unmapped), .page_wr_en(page_wr_en), .page_wr_data(page_wr_data),
        .call_req(call_req), .call_indirect(call_indirect), .call_imm_page(call_imm_page),
        .call_target(call_target), .call_ret_addr(call_ret_addr), .rtc_req(rtc_req),
        .fetch_ack(fetch_ack), .fetch_page(fetch_page), .fetch_target(fetch_target),
        .stack_ack(stack_ack), .stack_rdata(stack_rdata), .portk_gpio_out(8'hA5),
        .portk_gpio_oe(8'h5A), .page_index_bits(page_index_bits),
        .window_internal(window_internal), .fetch_req(fetch_req), .stack_req(stack_req),
        .stack_write(stack_write), .stack_wdata(stack_wdata), .pc_load(pc_load),
        .pc_value(pc_value), .queue_refill(queue_refill), .irq_inhibit(irq_inhibit),
        .seq_done(seq_done), .portk_out(portk_out), .portk_oe(portk_oe)
    );
    page_stack_model page_stack_model_inst (
        .clk_sys(clk_sys), .slow(slow), .fetch_req(fetch_req), .stack_req(stack_req),
        .stack_write(stack_write), .stack_wdata(stack_wdata), .fetch_ack(fetch_ack),
        .fetch_page(fetch_page), .fetch_target(fetch_target), .stack_ack(stack_ack),
        .stack_rdata(stack_rdata)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic store(input logic [5:0] d);
        page_wr_en = 1'b1;
        page_wr_data = d;
        @(negedge clk_sys);
        page_wr_en = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask
    task automatic run_seq(input logic is_call, input logic ind);
        int pulses;
        pulses = 0;
        call_req = is_call;
        rtc_req = !is_call;
        call_indirect = ind;
        @(negedge clk_sys);
        call_req = 1'b0;
        rtc_req = 1'b0;
        for (int i = 0; i < 60 && seq_done !== 1'b1; i++) begin
            check(irq_inhibit, 16'h1);
            pulses += (pc_load === 1'b1) ? 1 : 0;
            @(negedge clk_sys);
        end
        check(seq_done, 16'h1);
        check(queue_refill, 16'h1);
        check(pulses[15:0], 16'h1);
    endtask
    // Select low when the memory behind the region is allocated
    function automatic logic [7:0] exp_port(input logic [1:0] rg, input logic [5:0] pg,
                                            input logic intl);
        logic sel_n;
        logic [5:0] xab;
        case (rg)
            2'h0: sel_n = !(alloc_code == page_pkg::ALLOC_64K && !rom_high_map_bit);
            2'h1: sel_n = !(alloc_code[1] && !rom_high_map_bit);
            2'h2: sel_n = !(alloc_code == page_pkg::ALLOC_0K || (alloc_code[1] && intl));
            default: sel_n = 1'b0;
        endcase
        xab = rg == 2'h0 ? 6'h3D : rg == 2'h1 ? 6'h3E : rg == 2'h2 ? pg : 6'h3F;
        return {sel_n, !sel_n || !(bus_external && !bus_unmapped), xab};
    endfunction

    // ------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
    initial begin
        logic [5:0] bnd;
        {clk_en, reset, expanded_mode, portk_emulation_enable, bus_valid} = 5'h1F;
        {rom_high_map_bit, page_write_lock, bus_unmapped, page_wr_en, call_req} = 5'h0;
        {call_indirect, rtc_req, slow} = 3'h0;
        bus_external = 1'b1;
        {partition_straps, alloc_code, page_wr_data, call_imm_page} = 16'h0;
        {bus_addr, call_target, call_ret_addr} = 48'h0;
        fails = 0;
        num_checks = 0;
        repeat (5) @(negedge clk_sys);
        reset = 1'b0;
        check(page_index_bits, 16'h0);
        store(6'h15);
        check(page_index_bits, 16'h0015);
        page_write_lock = 1'b1;
        store(6'h2A);
        check(page_index_bits, 16'h0015);
        page_write_lock = 1'b0;
        clk_en = 1'b0;
        store(6'h2A);
        clk_en = 1'b1;
        check(page_index_bits, 16'h0015);
        for (int s = 0; s < 4; s++) begin
            partition_straps = s[1:0];
            bnd = s == 0 ? 6'h38 : s == 1 ? 6'h30 : s == 2 ? 6'h20 : 6'h00;
            store(bnd);
            check(window_internal, 16'h1);
            store(bnd - 6'h1);
            check(window_internal, (s == 3) ? 16'h1 : 16'h0);
        end
        partition_straps = page_pkg::STRAP_128K;
        for (int p = 0; p < 2; p++) begin
            bnd = p[0] ? 6'h38 : 6'h37;
            store(bnd);
            for (int k = 0; k < 32; k++) begin
                {alloc_code, rom_high_map_bit, bus_addr[15:14]} = k[4:0];
                @(negedge clk_sys);
                check(portk_out, exp_port(bus_addr[15:14], bnd, p[0]));
                check(portk_oe, 16'h00FF);
            end
        end
        {alloc_code, bus_addr[15:14], bus_unmapped} = 5'b01011;
        @(negedge clk_sys);
        check(portk_out, exp_port(2'h1, 6'h38, 1'b1));
        {bus_addr[15:14], bus_valid} = 3'b110;
        @(negedge clk_sys);
        check(portk_out, 16'h00FF);
        bus_valid = 1'b1;
        @(negedge clk_sys);
        check(portk_out, 16'h007F);
        bus_unmapped = 1'b0;
        expanded_mode = 1'b0;
        @(negedge clk_sys);
        check(portk_out, 16'h00E5);
        check(portk_oe, 16'h00DA);
        portk_emulation_enable = 1'b0;
        @(negedge clk_sys);
        check({portk_out, portk_oe}, 16'hA55A);
        store(6'h07);
        {call_imm_page, call_target, call_ret_addr} = {6'h15, 16'h9ABC, 16'h4321};
        run_seq(1'b1, 1'b0);
        check(pc_value, 16'h9ABC);
        check(page_index_bits, 16'h0015);
        check(page_stack_model_inst.mem[0], 16'h4321);
        check(page_stack_model_inst.mem[1], 16'h0007);
        run_seq(1'b0, 1'b0);
        check(pc_value, 16'h4321);
        check(page_index_bits, 16'h0007);
        slow = 1'b1;
        run_seq(1'b1, 1'b1);
        check(pc_value, 16'hA55A);
        check(page_index_bits, 16'h002A);
        run_seq(1'b0, 1'b0);
        check(page_index_bits, 16'h0007);
        check(pc_value, 16'h4321);
        report_and_stop();
    end
endmodule // tb_program_page_expansion_decode
